// File: rtl/pll_holdover_ctrl.sv
// holdover, lock detect, frequency monitor and VCO calibration control with Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
module pll_holdover_ctrl (
	input  wire logic                           clk_sys,
	input  wire logic                           arst_n,
	input  wire logic [pll_hold_pkg::ADDR_W-1:0] address,
	input  wire logic                           read,
	input  wire logic                           write,
	input  wire logic [pll_hold_pkg::DATA_W-1:0] writedata,
	input  wire logic [3:0]                     byteenable,
	output logic      [pll_hold_pkg::DATA_W-1:0] readdata,
	output logic                                waitrequest,
	input  wire pll_hold_pkg::pllPins_t         pins,
	output var pll_hold_pkg::pllCtl_t           ctl
);
	import pll_hold_pkg::*;

	typedef struct packed {
		logic                      waitReq;
		logic [DATA_W-1:0]         rdata;
		logic [NUM_CFG-1:0][7:0]   bufReg;
		logic [NUM_CFG-1:0][7:0]   actReg;
		logic                      calBitPrev;
		holdState_t                ho;
		logic [7:0]                lockCnt;
		calState_t                 cal;
		logic [3:0]                divCnt;
		logic [12:0]               calCnt;
		logic                      calDone;
		logic [2:0]                monStat;
		pllCtl_t                   ctl;
	} blkState_t;

	blkState_t s_q;
	blkState_t s_d;

	pllPins_t  pinLvl;
	pllPins_t  pinRise;
	logic      pfdEvt;
	logic      sensed;
	logic      holdOn;
	logic      autoOn;
	logic      calTick;
	logic      calStart;
	logic [7:0] lockTarget;
	logic [4:0] calDiv;

	// async comparator and divider outputs, two flops before use
	pin_sync #(.W($bits(pllPins_t))) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.raw     (pins),
		.level   (pinLvl),
		.rise    (pinRise)
	);

	function automatic logic [3:0] slotOf(input logic [9:0] idx);
		unique case (idx)
			IDX_LOCK_CAL: slotOf = {1'b1, SLOT_LOCK_CAL};
			IDX_PIN_SEL:  slotOf = {1'b1, SLOT_PIN_SEL};
			IDX_MON_SEL:  slotOf = {1'b1, SLOT_MON_SEL};
			IDX_REF_CTL:  slotOf = {1'b1, SLOT_REF_CTL};
			IDX_HOLD_CTL: slotOf = {1'b1, SLOT_HOLD_CTL};
			default:      slotOf = 4'h0;
		endcase
	endfunction

	function automatic logic [7:0] lockCycles(input logic [1:0] code);
		unique case (code)
			2'h0: lockCycles = LOCK_CYC0;
			2'h1: lockCycles = LOCK_CYC1;
			2'h2: lockCycles = LOCK_CYC2;
			2'h3: lockCycles = LOCK_CYC3;
		endcase
	endfunction

	// divide-by 2, 4, 8 or 16 of the PHASE_FREQUENCY_DETECTOR clock
	function automatic logic [4:0] calDivOf(input logic [1:0] code);
		calDivOf = 5'h02 << code;
	endfunction

	logic [7:0] lockCal;
	logic [7:0] pinSel;
	logic [7:0] refCtl;
	logic [7:0] holdCtl;
	assign lockCal = s_q.actReg[SLOT_LOCK_CAL];
	assign pinSel  = s_q.actReg[SLOT_PIN_SEL];
	assign refCtl  = s_q.actReg[SLOT_REF_CTL];
	assign holdCtl = s_q.actReg[SLOT_HOLD_CTL];

	// holdover tracks whichever reference is selected now
	assign pfdEvt = refCtl[SECOND_REFERENCE_INPUT_SEL_BIT] ? pinRise.refEdge2 : pinRise.refEdge1;
	assign sensed = holdCtl[COMP_EN_BIT] ? pinLvl.lockPin : 1'b1;
	assign holdOn = holdCtl[HOLD_A_BIT] & holdCtl[HOLD_B_BIT];
	// holdover resets N during calibration, so it is held off meanwhile
	assign autoOn = holdOn & ~holdCtl[EXT_HOLD_BIT] & (s_q.cal == CAL_IDLE);
	assign lockTarget = lockCycles(lockCal[LOCK_CNT_LSB +: 2]);
	assign calDiv = calDivOf(lockCal[CAL_DIV_LSB +: 2]);
	assign calTick = pfdEvt & ({1'b0, s_q.divCnt} == calDiv - 5'h01);
	assign calStart = lockCal[CAL_BIT] & ~s_q.calBitPrev;

	always_comb begin
		logic       req;
		logic [3:0] slot;
		logic [9:0] idx;
		logic       dldNext;
		req = read | write;
		idx = address[11:2];
		slot = slotOf(idx);
		dldNext = s_q.ctl.dldOut;
		s_d = s_q;
		s_d.ctl.bReset = 1'b0;

		// bus: one wait cycle, completion at the edge where waitrequest is seen low
		s_d.waitReq = ~(req & s_q.waitReq);
		if (read & s_q.waitReq) begin
			s_d.rdata = '0;
			if (address[1:0] == 2'h0) begin
				if (slot[3]) begin
					s_d.rdata[7:0] = s_q.bufReg[slot[2:0]];
				end else if (idx == IDX_STATUS) begin
					s_d.rdata[7:0] = {1'b0, s_q.calDone, 2'h0, s_q.monStat,
						s_q.ctl.dldOut};
				end
			end
		end
		if (write & ~s_q.waitReq & byteenable[0] & (address[1:0] == 2'h0)) begin
			if (slot[3]) begin
				s_d.bufReg[slot[2:0]] = writedata[7:0];
			end else if (idx == IDX_UPDATE && writedata[UPDATE_BIT]) begin
				s_d.actReg = s_q.bufReg;
			end
		end

		// digital lock detect, evaluated once per reference edge
		if (lockCal[DLD_OFF_BIT]) begin
			dldNext = 1'b0;
			s_d.lockCnt = '0;
		end else if (pfdEvt) begin
			if (pinLvl.overUnlock) begin
				dldNext = 1'b0;
				s_d.lockCnt = '0;
			end else if (pinLvl.inLockWin) begin
				if (s_q.lockCnt >= lockTarget - 8'h01) begin
					dldNext = 1'b1;
				end else begin
					s_d.lockCnt = s_q.lockCnt + 8'h01;
				end
			end else begin
				s_d.lockCnt = '0;
			end
		end
		s_d.ctl.dldOut = dldNext;
		s_d.ctl.csCharge = (pinSel[5:0] == CS_LOCK_CODE) & dldNext;
		s_d.ctl.ldSel = pinSel[5:0];
		s_d.ctl.lockWinHigh = ~lockCal[LOCK_WIN_BIT];
		s_d.ctl.refMonExt = {pinSel[MON2_EXT_BIT], pinSel[MON1_EXT_BIT]};
		s_d.ctl.refBufEn = refCtl[REF_BUF_LSB +: 2];
		s_d.ctl.refSelect2 = refCtl[SECOND_REFERENCE_INPUT_SEL_BIT];
		s_d.ctl.clkFeedback = refCtl[CLK_FB_BIT];

		// VCO monitor follows CLK when CLK feeds the N divider
		s_d.monStat = {refCtl[CLK_FB_BIT] ? pinLvl.clkInLow : pinLvl.vcoLow,
			pinLvl.ref2Low, pinLvl.ref1Low};

		// automatic holdover
		unique case (s_q.ho)
			HO_TRACK: begin
				if (autoOn & ~sensed) begin
					s_d.ho = HO_HIZ;
					s_d.ctl.cpHiZ = 1'b1;
				end
			end
			HO_HIZ: begin
				if (pfdEvt) begin
					s_d.ho = HO_REARM;
					s_d.ctl.cpHiZ = 1'b0;
					s_d.ctl.bReset = 1'b1;
				end
			end
			HO_REARM: begin
				if (sensed) begin
					s_d.ho = HO_TRACK;
				end
			end
			default: begin
				s_d.ho = HO_TRACK;
				s_d.ctl.cpHiZ = 1'b0;
			end
		endcase
		if (!holdOn) begin
			s_d.ho = HO_TRACK;
			s_d.ctl.cpHiZ = 1'b0;
		end

		// calibration, started only by a rise of the applied calibrate bit
		s_d.calBitPrev = lockCal[CAL_BIT];
		unique case (s_q.cal)
			CAL_IDLE: begin
				if (calStart) begin
					s_d.cal = CAL_RUN;
					s_d.calDone = 1'b0;
					s_d.divCnt = '0;
					s_d.calCnt = '0;
					s_d.ctl.outSync = 1'b1;
				end
			end
			CAL_RUN: begin
				if (calTick) begin
					s_d.divCnt = '0;
					if (s_q.calCnt == CAL_CYCLES - 13'h0001) begin
						s_d.cal = CAL_IDLE;
						s_d.calDone = 1'b1;
						s_d.ctl.outSync = 1'b0;
					end else begin
						s_d.calCnt = s_q.calCnt + 13'h0001;
					end
				end else if (pfdEvt) begin
					s_d.divCnt = s_q.divCnt + 4'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.waitReq <= 1'b1;
			s_q.bufReg <= {NUM_CFG{RST_CFG}};
			s_q.actReg <= {NUM_CFG{RST_CFG}};
			s_q.ho <= HO_TRACK;
			s_q.cal <= CAL_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata    = s_q.rdata;
	assign waitrequest = s_q.waitReq;
	assign ctl         = s_q.ctl;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_hiz_on_unlock: assert property ((s_q.ho == HO_TRACK) && autoOn && !sensed
		|=> s_q.ctl.cpHiZ)
		else $error("charge pump not released to high impedance on lock loss");
	a_comp_off_high: assert property ((s_q.ho == HO_TRACK) && !holdCtl[COMP_EN_BIT]
		|=> !s_q.ctl.cpHiZ)
		else $error("holdover entered with comparator disabled");
	a_hiz_holds: assert property (s_q.ctl.cpHiZ && !pfdEvt && holdOn
		|=> s_q.ctl.cpHiZ)
		else $error("charge pump left high impedance without reference edge");
	a_breset_on_exit: assert property ($fell(s_q.ctl.cpHiZ) && $past(holdOn) && holdOn
		|-> s_q.ctl.bReset ##1 !s_q.ctl.bReset)
		else $error("B counter reset missing or too long at holdover exit");
	a_rearm_wait: assert property ((s_q.ho == HO_REARM) && !sensed
		|=> !s_q.ctl.cpHiZ)
		else $error("holdover re-entered before pin recharged");
	a_hold_disabled: assert property (!holdOn |=> !s_q.ctl.cpHiZ)
		else $error("charge pump high impedance while holdover disabled");
	a_dld_unlock: assert property (s_q.ctl.dldOut && pfdEvt && pinLvl.overUnlock
		|=> !s_q.ctl.dldOut)
		else $error("lock indication kept after unlock cycle");
	a_dld_count: assert property ($rose(s_q.ctl.dldOut)
		|-> $past(s_q.lockCnt) == lockTarget - 8'h01)
		else $error("lock indicated before the programmed count");
	a_done_low_run: assert property ((s_q.cal == CAL_RUN) || s_q.ctl.outSync
		|-> !s_q.calDone)
		else $error("done bit high during calibration");
	a_cal_length: assert property ($fell(s_q.ctl.outSync)
		|-> s_q.calDone && $past(s_q.calCnt) == CAL_CYCLES - 13'h0001)
		else $error("calibration ended at wrong cycle count");
	a_bus_answer: assert property ((read || write) && waitrequest
		|=> !waitrequest ##1 waitrequest)
		else $error("bus answer not given after one wait cycle");

	c_holdover_exit: cover property (s_q.ctl.cpHiZ ##1 s_q.ctl.bReset);
	c_cal_done: cover property ($fell(s_q.ctl.outSync));
	c_lock_seen: cover property ($rose(s_q.ctl.dldOut));
	c_reg_update: cover property (write && !waitrequest && address[11:2] == IDX_UPDATE);
endmodule // pll_holdover_ctrl
`default_nettype wire

// File: rtl/pll_hold_pkg.sv
// package: register map, field layout, pin carriers and states of the holdover/calibration block
// Summary of operation
// - auto holdover enabled: charge pump goes high impedance as soon as lock is lost outside calibration
// - holdover entry condition is the sensed level on the lock indicator pin
// - comparator-enable bit gates pin comparator; disabled means pin always sensed high
// - once in holdover, charge pump stays high impedance while no reference edge arrives
// - leaving holdover on a reference edge resets the B counter, never the prescaler
// - after leaving holdover, pin must read high again before re-entry
// - holdover follows the selected reference; switchover loss holds until next edge
// - two-bit lock counter sets consecutive in-window cycles; code 00 means five
// - pin select code 000100b selects current-source lock detect mode
// - both holdover enable bits needed; otherwise no holdover of any kind acts
// - external-holdover bit at 0 selects internal automatic holdover on lock loss
// - lock window bit at 0 selects the high-range lock window
// - three monitors flag references or VCO below threshold; VCO one may watch CLK
// - reference monitors have normal/extended thresholds; results read as three status bits
// - calibration is clocked from the divided reference and needs the reference present
// - first calibration after reset starts once the calibrate bit is set and applied
// - status bit reads one once a calibration has finished
// - calibration holds outputs in sync, calibrates, then releases sync and closes loop
// - calibration clock is PHASE_FREQUENCY_DETECTOR clock over divider field; a run is 4400 such cycles
// - lock asserts after programmed consecutive in-window cycles, drops on one unlock cycle
package pll_hold_pkg;
	localparam int          ADDR_W = 12;
	localparam int          DATA_W = 32;
	localparam logic [9:0]  IDX_LOCK_CAL = 10'h018;
	localparam logic [9:0]  IDX_PIN_SEL  = 10'h01A;
	localparam logic [9:0]  IDX_MON_SEL  = 10'h01B;
	localparam logic [9:0]  IDX_REF_CTL  = 10'h01C;
	localparam logic [9:0]  IDX_HOLD_CTL = 10'h01D;
	localparam logic [9:0]  IDX_STATUS   = 10'h01F;
	localparam logic [9:0]  IDX_UPDATE   = 10'h232;
	localparam int          NUM_CFG      = 5;
	localparam logic [2:0]  SLOT_LOCK_CAL = 3'h0;
	localparam logic [2:0]  SLOT_PIN_SEL  = 3'h1;
	localparam logic [2:0]  SLOT_MON_SEL  = 3'h2;
	localparam logic [2:0]  SLOT_REF_CTL  = 3'h3;
	localparam logic [2:0]  SLOT_HOLD_CTL = 3'h4;
	localparam logic [7:0]  RST_CFG      = 8'h00;
	localparam int          CAL_BIT      = 0;
	localparam int          CAL_DIV_LSB  = 1;
	localparam int          DLD_OFF_BIT  = 3;
	localparam int          LOCK_WIN_BIT = 4;
	localparam int          LOCK_CNT_LSB = 5;
	localparam int          MON1_EXT_BIT = 6;
	localparam int          MON2_EXT_BIT = 7;
	localparam int          REF_BUF_LSB  = 1;
	localparam int          SECOND_REFERENCE_INPUT_SEL_BIT = 6;
	localparam int          CLK_FB_BIT   = 7;
	localparam int          HOLD_A_BIT   = 0;
	localparam int          EXT_HOLD_BIT = 1;
	localparam int          HOLD_B_BIT   = 2;
	localparam int          COMP_EN_BIT  = 3;
	localparam int          UPDATE_BIT   = 0;
	localparam logic [5:0]  CS_LOCK_CODE = 6'h04;
	localparam logic [12:0] CAL_CYCLES   = 13'h1130;
	localparam logic [7:0]  LOCK_CYC0    = 8'h05;
	localparam logic [7:0]  LOCK_CYC1    = 8'h10;
	localparam logic [7:0]  LOCK_CYC2    = 8'h40;
	localparam logic [7:0]  LOCK_CYC3    = 8'hFF;

	typedef struct packed {
		logic refEdge1;
		logic refEdge2;
		logic lockPin;
		logic inLockWin;
		logic overUnlock;
		logic ref1Low;
		logic ref2Low;
		logic vcoLow;
		logic clkInLow;
	} pllPins_t;

	typedef struct packed {
		logic       cpHiZ;
		logic       bReset;
		logic       outSync;
		logic       dldOut;
		logic       csCharge;
		logic       lockWinHigh;
		logic [1:0] refMonExt;
		logic [1:0] refBufEn;
		logic [5:0] ldSel;
		logic       refSelect2;
		logic       clkFeedback;
	} pllCtl_t;

	typedef enum logic [1:0] {HO_TRACK, HO_HIZ, HO_REARM} holdState_t;
	typedef enum logic {CAL_IDLE, CAL_RUN} calState_t;
endpackage

// File: rtl/pin_sync.sv
// two-flop synchroniser with a rising-edge pulse for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} syncState_t;

	syncState_t s_q;
	syncState_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = raw;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.sync;
	assign rise  = s_q.sync & ~s_q.prev;
endmodule // pin_sync
`default_nettype wire

// File: test/ref_source.sv
// reference clock source model driving the divided reference pin
`timescale 1ns/10ps
`default_nettype none
module ref_source (
	input  wire logic clk_sys,
	input  wire logic run,
	output logic      refOut,
	output int        rises
);
	logic [1:0] ph_q;
	initial begin
		refOut = 1'b0;
		rises = 0;
		ph_q = 2'h0;
	end
	// stands still while stopped; 3 cycles per level keeps edges above the sync limit
	always @(posedge clk_sys) begin
		if (run) begin
			ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
			if (ph_q == 2'h2) begin
				refOut <= ~refOut;
				rises <= rises + (refOut ? 0 : 1);
			end
		end
	end
endmodule // ref_source
`default_nettype wire

// File: test/pll_holdover_and_vco_calibration_tb.sv
// self-checking bench for the holdover, lock detect, monitor and calibration block
`timescale 1ns/10ps
`default_nettype none
module pll_holdover_and_vco_calibration_tb;
	import pll_hold_pkg::*;
	logic              clk_sys;
	logic              arst_n;
	logic [ADDR_W-1:0] address;
	logic              read;
	logic              write;
	logic [DATA_W-1:0] writedata;
	logic [3:0]        byteenable;
	logic [DATA_W-1:0] readdata;
	logic              waitrequest;
	pllPins_t          pinsTb;
	pllPins_t          pins;
	pllCtl_t           ctl;
	logic              refRun;
	logic              first_reference_input;
	int                rises;
	int                err_total;
	int                checks;
	int                cyc = 0;
	int                r0;
	int                n;
	logic [31:0]       rd;
	assign pins = {first_reference_input, pinsTb[7:0]};
	pll_holdover_ctrl uut (.clk_sys(clk_sys), .arst_n(arst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .pins(pins), .ctl(ctl));
	ref_source src (.clk_sys(clk_sys), .run(refRun), .refOut(first_reference_input), .rises(rises));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
		input logic [3:0] be);
		int k;
		k = 0;
		@(posedge clk_sys);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, wd};
		byteenable <= be;
		do begin
			@(posedge clk_sys);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (k >= 50) check("waitrequest", 32'h1, 32'h0);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] v);
		bus(1'b1, idx, v, 4'hF);
	endtask
	task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00, 4'hF);
		check(what, rd, exp);
	endtask
	task automatic upd();
		wr(IDX_UPDATE, 8'h01);
	endtask
	task automatic cycles(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic reg_test();
		rdc("lockCal", IDX_LOCK_CAL, 32'h0);
		wr(IDX_MON_SEL, 8'hF7);
		bus(1'b1, IDX_MON_SEL, 8'h12, 4'hE);
		rdc("monSel", IDX_MON_SEL, 32'hF7);
		wr(10'h019, 8'h55);
		rdc("unmapped", 10'h019, 32'h0);
		rdc("update", IDX_UPDATE, 32'h0);
		$display("test reg done");
	endtask
	task automatic lock_test();
		wr(IDX_PIN_SEL, 8'hC4);
		wr(IDX_LOCK_CAL, 8'h00);
		wr(IDX_REF_CTL, 8'h86);
		upd();
		pinsTb.overUnlock <= 1'b1;
		cycles(20);
		check("ldSel", 32'(ctl.ldSel), 32'h04);
		check("lockWinHigh", 32'(ctl.lockWinHigh), 32'h1);
		check("refMonExt", 32'(ctl.refMonExt), 32'h3);
		check("dldIdle", 32'(ctl.dldOut), 32'h0);
		// change window inputs mid-period so the next rising edge is the first counted
		@(negedge first_reference_input);
		r0 = rises;
		@(posedge clk_sys);
		pinsTb.overUnlock <= 1'b0;
		pinsTb.inLockWin <= 1'b1;
		n = 0;
		while (ctl.dldOut !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		check("lockEdges", 32'(rises - r0), 32'd5);
		bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
		check("dldStat", 32'(rd[0]), 32'h1);
		check("csCharge", 32'(ctl.csCharge), 32'h1);
		pinsTb.overUnlock <= 1'b1;
		cycles(15);
		check("dldDrop", 32'(ctl.dldOut), 32'h0);
		$display("test lock done");
	endtask
	task automatic monitor_test();
		pinsTb.ref1Low <= 1'b1;
		pinsTb.vcoLow <= 1'b1;
		cycles(10);
		bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
		check("mon1", 32'(rd[3:1]), 32'h1);
		check("clkFb", 32'(ctl.clkFeedback), 32'h1);
		pinsTb.ref1Low <= 1'b0;
		pinsTb.ref2Low <= 1'b1;
		pinsTb.vcoLow <= 1'b0;
		pinsTb.clkInLow <= 1'b1;
		cycles(10);
		bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
		check("mon2", 32'(rd[3:1]), 32'h6);
		$display("test monitor done");
	endtask
	task automatic hold_try(input logic [7:0] cfg, input string what);
		pinsTb.lockPin <= 1'b1;
		wr(IDX_HOLD_CTL, cfg);
		upd();
		cycles(10);
		pinsTb.lockPin <= 1'b0;
		cycles(10);
		check(what, 32'(ctl.cpHiZ), 32'h0);
	endtask
	task automatic holdover_test();
		refRun <= 1'b0;
		pinsTb.lockPin <= 1'b1;
		wr(IDX_HOLD_CTL, 8'h0D);
		upd();
		cycles(10);
		check("cpIdle", 32'(ctl.cpHiZ), 32'h0);
		pinsTb.lockPin <= 1'b0;
		cycles(10);
		check("cpEnter", 32'(ctl.cpHiZ), 32'h1);
		cycles(200);
		check("cpHold", 32'(ctl.cpHiZ), 32'h1);
		refRun <= 1'b1;
		n = 0;
		while (ctl.bReset !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		check("bReset", 32'(ctl.bReset), 32'h1);
		check("cpExit", 32'(ctl.cpHiZ), 32'h0);
		cycles(30);
		check("noReenter", 32'(ctl.cpHiZ), 32'h0);
		refRun <= 1'b0;
		wr(IDX_HOLD_CTL, 8'h05);
		upd();
		cycles(10);
		check("compOff", 32'(ctl.cpHiZ), 32'h0);
		hold_try(8'h0F, "extHold");
		hold_try(8'h09, "oneEnable");
		wr(IDX_HOLD_CTL, 8'h00);
		upd();
		refRun <= 1'b1;
		$display("test holdover done");
	endtask
	task automatic cal_test();
		wr(IDX_LOCK_CAL, 8'h01);
		upd();
		n = 0;
		while (ctl.outSync !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		r0 = rises;
		check("syncOn", 32'(ctl.outSync), 32'h1);
		bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
		check("calBusy", 32'(rd[6]), 32'h0);
		n = 0;
		while (ctl.outSync !== 1'b0 && n < 60000) begin
			@(posedge clk_sys);
			n++;
		end
		check("calLen", 32'((rises - r0) >= 8799 && (rises - r0) <= 8801), 32'h1);
		bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
		check("calDone", 32'(rd[6]), 32'h1);
		wr(IDX_LOCK_CAL, 8'h01);
		upd();
		cycles(20);
		check("noRecal", 32'(ctl.outSync), 32'h0);
		$display("test cal done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ceiling sized from the calibration run of about 53000 cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		arst_n = 1'b0;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'h0;
		pinsTb = '0;
		refRun = 1'b1;
		err_total = 0;
		checks = 0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		reg_test();
		lock_test();
		monitor_test();
		holdover_test();
		cal_test();
		summarize();
	end
endmodule // pll_holdover_and_vco_calibration_tb
`default_nettype wire
